// [emw_pkg.sv]
// Shared constants and types of the serial EEPROM command port
package emw_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CORE_CLK_MHZ    = 250;
   localparam int PROG_TIME_US    = 5000;
   localparam int PROG_CYCLES     = PROG_TIME_US * CORE_CLK_MHZ;
   localparam int RST_HOLD_MS     = 240;
   localparam int RST_HOLD_CYCLES = RST_HOLD_MS * 1000 * CORE_CLK_MHZ;
   localparam int PROG_CNT_W      = 21;
   localparam int RST_CNT_W       = 26;

   // ----------------------------------------------------------------
   // Frame layout and memory geometry (4-Kbit array)
   // ----------------------------------------------------------------
   localparam int         SYNC_W        = 5;
   localparam int         ADDR_W        = 9;
   localparam int         MEM_BYTES     = 512;
   localparam logic [4:0] OPC_LAST      = 5'h01;
   localparam logic [4:0] ADDR_BITS_X16 = 5'h08;
   localparam logic [4:0] ADDR_BITS_X8  = 5'h09;
   localparam logic [4:0] WORD_BITS_X16 = 5'h10;
   localparam logic [4:0] WORD_BITS_X8  = 5'h08;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;

   // ----------------------------------------------------------------
   // Opcodes and extended codes
   // ----------------------------------------------------------------
   localparam logic [1:0] OPC_EXT      = 2'h0;
   localparam logic [1:0] OPC_WRITE    = 2'h1;
   localparam logic [1:0] OPC_READ     = 2'h2;
   localparam logic [1:0] OPC_ERASE    = 2'h3;
   localparam logic [1:0] EXT_DISABLE  = 2'h0;
   localparam logic [1:0] EXT_FILL_ALL = 2'h1;
   localparam logic [1:0] EXT_CLR_ALL  = 2'h2;
   localparam logic [1:0] EXT_ENABLE   = 2'h3;

   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_HOLD} emw_state_type;
   typedef enum logic [1:0] {OP_WRITE, OP_ERASE, OP_CLR_ALL, OP_FILL_ALL} emw_op_type;

endpackage : emw_pkg

// [emw_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module emw_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk, // Core clock
   input  wire logic         rst,      // Async reset, active high
   input  wire logic [W-1:0] async_in, // Pins from outside the domain
   output logic      [W-1:0] sync_out  // Synchronised levels
);
   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------
   // One two-flop chain per bit
   // ----------------------------------------------------------------
   for (genvar g = 0; g < W; g++)
   begin : g_bit
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
         begin
            meta_q[g]   <= 1'b0;
            sync_out[g] <= 1'b0;
         end
         else
         begin
            meta_q[g]   <= async_in[g];
            sync_out[g] <= meta_q[g];
         end
      end
   end
endmodule : emw_sync

// [emw_supervisor.sv]
// Supply supervisor: reset output with hold-off timeout
`timescale 1ns/1ps
module emw_supervisor #(
   parameter int unsigned HOLD_CYCLES = emw_pkg::RST_HOLD_CYCLES,
   parameter bit          ACTIVE_HIGH = 1'b0
) (
   input  wire logic core_clk,  // Core clock
   input  wire logic rst,       // Async reset, active high
   input  wire logic supply_ok, // Synchronised comparator level
   output logic      reset_out  // Push-pull reset, fixed polarity
);
   import emw_pkg::*;

   logic [RST_CNT_W-1:0] hold_cnt_q;
   logic                 active_d;

   // Counter restarts on every dip, so a brownout always earns a full hold
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         hold_cnt_q <= '0;
      else if (!supply_ok)
         hold_cnt_q <= '0;
      else if (hold_cnt_q != RST_CNT_W'(HOLD_CYCLES))
         hold_cnt_q <= hold_cnt_q + 1'b1;
   end

   assign active_d = !supply_ok || (hold_cnt_q != RST_CNT_W'(HOLD_CYCLES));

   // Output driven both ways in either polarity
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         reset_out <= ACTIVE_HIGH;
      else
         reset_out <= active_d ~^ ACTIVE_HIGH;
   end
endmodule : emw_supervisor

// [emw_port.sv]
// Serial EEPROM command port with supply supervisor
// Operation
// - Frame: start bit one, two-bit opcode, address, then data for writes.
// - Address width follows density; byte mode adds one address bit.
// - Opcode 10 reads the word at the given address.
// - Opcode 11 erases the addressed location.
// - Opcode 01 writes the following data word to the address.
// - Opcode 00 uses top address bits: enable, disable, clear all, fill all.
// - Input bits are sampled on each rising serial clock edge.
// - Read data output changes on each rising serial clock edge.
// - Bits are accepted only while chip select is high.
// - Chip select falling after a program command starts the internal cycle.
// - Width select high gives 16-bit words, low gives 8-bit words.
// - Data output floats except during read data or status reporting.
// - Status drives low while busy and high when ready.
// - A dummy one bit during status floats the data output.
// - Status may be turned off only when ready, never while busy.
// - Read output gives one leading zero, then the word MSB first.
// - Continued clocking reads successive words, wrapping to address zero.
// - Only the first word of a sequential read gets the leading zero.
// - Reset holds while supply is low and for a timeout after.
// - Reset output has a fixed polarity and is push-pull.
// - Writes start disabled; enable needed first; stay enabled until disabled.
// - Erased locations read as all ones.
// - Programming finishes within 5 ms without serial clock activity.
`timescale 1ns/1ps
module emw_port #(
   parameter int unsigned PROG_CYCLES     = emw_pkg::PROG_CYCLES,
   parameter int unsigned RST_HOLD_CYCLES = emw_pkg::RST_HOLD_CYCLES,
   parameter bit          RST_ACTIVE_HIGH = 1'b0
) (
   input  wire logic core_clk,          // Core clock, 250 MHz
   input  wire logic rst,               // Async reset, active high
   input  wire logic cs_pin,            // Chip select pin
   input  wire logic sk_pin,            // Serial clock pin
   input  wire logic di_pin,            // Serial data in pin
   input  wire logic word_width_select, // High: x16, low: x8
   input  wire logic supply_ok,         // Supply above threshold
   output logic      do_o,              // Serial data out level
   output logic      do_oe,             // Serial data out enable
   output logic      reset_out          // Supervisor reset output
);
   import emw_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] addr_len(input logic x8);
      addr_len = x8 ? ADDR_BITS_X8 : ADDR_BITS_X16;
   endfunction : addr_len

   function automatic logic [4:0] word_len(input logic x8);
      word_len = x8 ? WORD_BITS_X8 : WORD_BITS_X16;
   endfunction : word_len

   // ----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] pins_s;
   logic              cs_s, sk_s, di_s, org_s, ok_s;
   logic              sk_d_q, cs_d_q;
   logic              sk_rise, cs_fall, x8;

   emw_sync #(.W(SYNC_W)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({cs_pin, sk_pin, di_pin, word_width_select, supply_ok}),
      .sync_out (pins_s)
   );
   assign {cs_s, sk_s, di_s, org_s, ok_s} = pins_s;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sk_d_q <= 1'b0;
         cs_d_q <= 1'b0;
      end
      else
      begin
         sk_d_q <= sk_s;
         cs_d_q <= cs_s;
      end
   end

   assign sk_rise = sk_s && !sk_d_q && cs_s;
   assign cs_fall = cs_d_q && !cs_s;
   assign x8      = !org_s;

   emw_supervisor #(.HOLD_CYCLES(RST_HOLD_CYCLES), .ACTIVE_HIGH(RST_ACTIVE_HIGH)) u_sup (
      .core_clk  (core_clk),
      .rst       (rst),
      .supply_ok (ok_s),
      .reset_out (reset_out)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   emw_state_type     st_q;
   emw_op_type        op_q;
   logic [4:0]        cnt_q;
   logic [1:0]        opc_q;
   logic [ADDR_W-1:0] addr_q, addr_n;
   logic [15:0]       data_q, sh_q, cur_word, prog_word;
   logic [1:0]        ext_code;
   logic              pend_q, wen_q, busy_q, stat_q, prog_start, stat_off;
   logic [PROG_CNT_W-1:0] prog_cnt_q;
   logic [7:0]        mem [0:MEM_BYTES-1];

   assign addr_n     = {addr_q[ADDR_W-2:0], di_s};
   assign ext_code   = x8 ? addr_n[8:7] : addr_n[7:6];
   assign prog_start = cs_fall && pend_q && wen_q && !busy_q;
   assign stat_off   = stat_q && st_q == ST_IDLE && sk_rise && di_s && !busy_q;
   assign prog_word  = (op_q == OP_WRITE || op_q == OP_FILL_ALL) ? data_q : {ERASED_BYTE, ERASED_BYTE};
   // Left-aligned word at the current address
   assign cur_word   = x8 ? {mem[addr_q], 8'h00} : {mem[{addr_q[7:0], 1'b0}], mem[{addr_q[7:0], 1'b1}]};

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q   <= ST_IDLE;
         op_q   <= OP_WRITE;
         cnt_q  <= '0;
         opc_q  <= '0;
         addr_q <= '0;
         data_q <= '0;
         sh_q   <= '0;
         pend_q <= 1'b0;
         wen_q  <= 1'b0;
         do_o   <= 1'b0;
         do_oe  <= 1'b0;
      end
      else if (!cs_s)
      begin
         st_q   <= ST_IDLE;
         pend_q <= 1'b0;
         do_oe  <= 1'b0;
      end
      else if (stat_q && st_q == ST_IDLE)
      begin
         do_oe <= 1'b1;
         do_o  <= !busy_q;
         if (stat_off)
         begin
            // The dummy one doubles as the next start bit
            do_oe  <= 1'b0;
            st_q   <= ST_OPC;
            cnt_q  <= '0;
            addr_q <= '0;
         end
      end
      else if (sk_rise)
      begin
         unique case (st_q)
            ST_IDLE:
               if (di_s)
               begin
                  st_q   <= ST_OPC;
                  cnt_q  <= '0;
                  addr_q <= '0;
               end
            ST_OPC:
            begin
               opc_q <= {opc_q[0], di_s};
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == OPC_LAST)
               begin
                  st_q  <= ST_ADDR;
                  cnt_q <= '0;
               end
            end
            ST_ADDR:
            begin
               addr_q <= addr_n;
               cnt_q  <= cnt_q + 1'b1;
               if (cnt_q == addr_len(x8) - 5'h01)
               begin
                  cnt_q <= '0;
                  st_q  <= ST_HOLD;
                  unique case (opc_q)
                     OPC_READ:
                     begin
                        st_q  <= ST_READ;
                        do_oe <= 1'b1;
                        do_o  <= 1'b0;
                     end
                     OPC_ERASE:
                     begin
                        op_q   <= OP_ERASE;
                        pend_q <= 1'b1;
                     end
                     OPC_WRITE:
                     begin
                        op_q <= OP_WRITE;
                        st_q <= ST_DATA;
                     end
                     OPC_EXT:
                        unique case (ext_code)
                           EXT_ENABLE:  wen_q <= 1'b1;
                           EXT_DISABLE: wen_q <= 1'b0;
                           EXT_CLR_ALL:
                           begin
                              op_q   <= OP_CLR_ALL;
                              pend_q <= 1'b1;
                           end
                           EXT_FILL_ALL:
                           begin
                              op_q <= OP_FILL_ALL;
                              st_q <= ST_DATA;
                           end
                        endcase
                  endcase
               end
            end
            ST_DATA:
            begin
               data_q <= {data_q[14:0], di_s};
               cnt_q  <= cnt_q + 1'b1;
               if (cnt_q == word_len(x8) - 5'h01)
               begin
                  st_q   <= ST_HOLD;
                  pend_q <= 1'b1;
               end
            end
            ST_READ:
            begin
               // Words run back to back; address wraps by its own width
               if (cnt_q == '0)
               begin
                  do_o   <= cur_word[15];
                  sh_q   <= {cur_word[14:0], 1'b0};
                  addr_q <= x8 ? addr_q + 1'b1 : {1'b0, addr_q[7:0] + 8'h01};
               end
               else
               begin
                  do_o <= sh_q[15];
                  sh_q <= {sh_q[14:0], 1'b0};
               end
               cnt_q <= (cnt_q == word_len(x8) - 5'h01) ? '0 : cnt_q + 1'b1;
            end
            ST_HOLD: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Self-timed programming cycle and status flag
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_q     <= 1'b0;
         prog_cnt_q <= '0;
      end
      else if (prog_start)
      begin
         busy_q     <= 1'b1;
         prog_cnt_q <= '0;
      end
      else if (busy_q)
      begin
         prog_cnt_q <= prog_cnt_q + 1'b1;
         if (prog_cnt_q == PROG_CNT_W'(PROG_CYCLES - 1))
            busy_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         stat_q <= 1'b0;
      else if (prog_start)
         stat_q <= 1'b1;
      else if (stat_off)
         stat_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Storage array, updated when the cycle starts
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < MEM_BYTES; i++)
            mem[i] <= ERASED_BYTE;
      end
      else if (prog_start)
      begin
         unique case (op_q)
            OP_WRITE, OP_ERASE:
               if (x8)
                  mem[addr_q] <= prog_word[7:0];
               else
               begin
                  mem[{addr_q[7:0], 1'b0}] <= prog_word[15:8];
                  mem[{addr_q[7:0], 1'b1}] <= prog_word[7:0];
               end
            OP_CLR_ALL, OP_FILL_ALL:
               for (int i = 0; i < MEM_BYTES; i++)
                  mem[i] <= (x8 || i[0]) ? prog_word[7:0] : prog_word[15:8];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_oe_cs_low: assert property (!cs_s |=> !do_oe) else $error("data out driven while deselected");
   chk_read_start: assert property (sk_rise && st_q == ST_ADDR && opc_q == OPC_READ
      && cnt_q == addr_len(x8) - 5'h01 |=> st_q == ST_READ && do_oe && !do_o) else $error("read did not start");
   chk_lead_zero: assert property ($rose(st_q == ST_READ) |-> do_oe && !do_o) else $error("no leading zero");
   chk_status_busy: assert property (stat_q && busy_q && cs_s && $past(cs_s) && st_q == ST_IDLE |=> !do_o)
      else $error("status not low while busy");
   chk_prog_enable: assert property ($rose(busy_q) |-> $past(wen_q) && $past(cs_fall)) else $error("cycle without enable");
   chk_prog_bound: assert property (busy_q |-> prog_cnt_q < PROG_CNT_W'(PROG_CYCLES)) else $error("cycle too long");
   chk_no_off_busy: assert property (busy_q && stat_q |=> stat_q) else $error("status dropped while busy");
   chk_ignore_zero: assert property (st_q == ST_IDLE && !stat_q && sk_rise && !di_s |=> st_q == ST_IDLE)
      else $error("zero taken as start");
   chk_start_prog: assert property (cs_fall && pend_q && wen_q && !busy_q |=> busy_q) else $error("cycle not started");
   chk_dummy_float: assert property (stat_off |=> !do_oe && st_q == ST_OPC) else $error("dummy bit ignored");

   cov_read: cover property (st_q == ST_READ && sk_rise && cnt_q == 5'h00 && $past(st_q) == ST_READ);
   cov_wrap: cover property (st_q == ST_READ && sk_rise && cnt_q == 5'h00 && addr_q == '0);
   cov_fill: cover property (prog_start && op_q == OP_FILL_ALL);
   cov_status_off: cover property (stat_off);
endmodule : emw_port

// [emw_host.sv]
// Host model that drives the serial link of the command port
`timescale 1ns/1ps
module emw_host (
   input  wire logic core_clk, // Core clock
   input  wire logic do_o,     // Data out level from the port
   input  wire logic do_oe,    // Data out enable from the port
   output logic      cs_pin,   // Chip select
   output logic      sk_pin,   // Serial clock, still outside frames
   output logic      di_pin,   // Serial data in
   output logic      do_w      // Resolved data out wire
);
   logic last_q;

   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // A released wire shows the inverse of its last level, so a stale copy never passes
   assign do_w = do_oe ? do_o : ~last_q;

   initial
   begin
      cs_pin = 1'b0;
      sk_pin = 1'b0;
      di_pin = 1'b0;
      last_q = 1'b0;
   end

   always @(posedge core_clk)
      if (do_oe)
         last_q <= do_o;

   // One clock period of 8 core cycles; r is the level left by the previous rise
   task automatic sbit(input logic b, output logic r);
      @(posedge core_clk);
      sk_pin <= 1'b0;
      di_pin <= b;
      repeat (3) @(posedge core_clk);
      r = do_w;
      @(posedge core_clk);
      sk_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask : sbit

   task automatic select();
      @(posedge core_clk);
      cs_pin <= 1'b1;
   endtask : select

   task automatic frame(input logic [31:0] bits, input int n);
      logic r;
      select();
      repeat ($urandom_range(2)) sbit(1'b0, r);
      for (int i = n - 1; i >= 0; i--) sbit(bits[i], r);
   endtask : frame

   task automatic deselect();
      @(posedge core_clk);
      sk_pin <= 1'b0;
      cs_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : deselect
endmodule : emw_host

// [testbench.sv]
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   import emw_pkg::*;
   localparam int PROG = 50;
   localparam int HOLD = 100;
   logic       core_clk, rst, word_width_select, supply_ok, en;
   logic       cs_pin, sk_pin, di_pin, do_w, do_o, do_oe, reset_out;
   logic [7:0] mem [MEM_BYTES];
   int         err_total, total_checks, cyc, k, a, top;

   emw_port #(.PROG_CYCLES(PROG), .RST_HOLD_CYCLES(HOLD)) u_dut (.core_clk(core_clk), .rst(rst),
      .cs_pin(cs_pin), .sk_pin(sk_pin), .di_pin(di_pin), .word_width_select(word_width_select),
      .supply_ok(supply_ok), .do_o(do_o), .do_oe(do_oe), .reset_out(reset_out));
   emw_host u_host (.core_clk(core_clk), .do_o(do_o), .do_oe(do_oe), .cs_pin(cs_pin),
      .sk_pin(sk_pin), .di_pin(di_pin), .do_w(do_w));

   always #2 core_clk = ~core_clk;

   // Cuts a hang short well above the expected run length
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Expectation model
   // ----------------------------------------------------------------
   function automatic logic [15:0] expw(input int wa);
      return word_width_select ? {mem[2*wa], mem[2*wa+1]} : {8'h00, mem[wa]};
   endfunction : expw

   function automatic int ext_a(input logic [1:0] c);
      return word_width_select ? int'(c) << 6 : int'(c) << 7;
   endfunction : ext_a

   // ----------------------------------------------------------------
   // Command tasks
   // ----------------------------------------------------------------
   task automatic op(input logic [1:0] opc, input int oa, input logic [15:0] d);
      logic [31:0] bits;
      logic [1:0]  code;
      int          n, w;
      logic        r;
      w = word_width_select ? 16 : 8;
      n = word_width_select ? 11 : 12;
      bits = {29'h0, 1'b1, opc} << (n - 3);
      bits = bits | oa;
      code = word_width_select ? oa[7:6] : oa[8:7];
      if (opc == OPC_WRITE || (opc == OPC_EXT && code == EXT_FILL_ALL))
      begin
         bits = (bits << w) | (w == 16 ? {16'h0, d} : {24'h0, d[7:0]});
         n += w;
      end
      u_host.frame(bits, n);
      u_host.deselect();
      if (opc == OPC_EXT && code == EXT_ENABLE) en = 1'b1;
      if (opc == OPC_EXT && code == EXT_DISABLE) en = 1'b0;
      if (en && !(opc == OPC_EXT && code[1] == code[0]))
      begin
         for (int i = 0; i < MEM_BYTES; i++)
            if (opc == OPC_EXT || i / (w / 8) == oa)
               mem[i] = (opc == OPC_ERASE || (opc == OPC_EXT && code == EXT_CLR_ALL)) ? ERASED_BYTE :
                        (w == 16 && i % 2 == 0) ? d[15:8] : d[7:0];
         u_host.select();
         repeat (6) @(posedge core_clk);
         `CHK({do_oe, do_w}, 2'b10);
         u_host.sbit(1'b1, r);
         repeat (5) @(posedge core_clk);
         `CHK({do_oe, do_w}, 2'b10);
         k = 0;
         while (do_w !== 1'b1 && k < PROG + 40)
         begin
            @(posedge core_clk);
            k++;
         end
         `CHK({do_oe, do_w, k < PROG + 20}, 3'b111);
         u_host.sbit(1'b1, r);
         repeat (5) @(posedge core_clk);
         `CHK(do_oe, 1'b0);
         u_host.deselect();
      end
   endtask : op

   task automatic rd(input int ra, input int nw);
      logic        r;
      logic [15:0] got;
      int          w;
      w = word_width_select ? 16 : 8;
      u_host.frame(word_width_select ? {21'h0, 1'b1, OPC_READ, ra[7:0]} : {20'h0, 1'b1, OPC_READ, ra[8:0]},
                   word_width_select ? 11 : 12);
      u_host.sbit(1'b0, r);
      `CHK({do_oe, r}, 2'b10);
      for (int j = 0; j < nw; j++)
      begin
         got = 16'h0000;
         for (int i = 0; i < w; i++)
         begin
            u_host.sbit(1'b0, r);
            got = {got[14:0], r};
         end
         `CHK(got, expw((ra + j) % top));
      end
      u_host.deselect();
      repeat (2) @(posedge core_clk);
      `CHK(do_oe, 1'b0);
   endtask : rd

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      rst = 1'b1;
      word_width_select = 1'b1;
      supply_ok = 1'b0;
      en = 1'b0;
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      void'($urandom(32'h2a60d217));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK({do_oe, reset_out}, 2'b00);
      supply_ok <= 1'b1;
      k = 0;
      while (reset_out !== 1'b1 && k < HOLD + 50)
      begin
         @(posedge core_clk);
         k++;
      end
      `CHK(k >= HOLD && k <= HOLD + 8, 1'b1);
      for (int m = 1; m >= 0; m--)
      begin
         word_width_select <= m[0];
         @(posedge core_clk);
         top = m ? 256 : 512;
         a = $urandom_range(top - 1);
         op(OPC_WRITE, a, 16'($urandom));
         rd(a, 1);
         op(OPC_EXT, ext_a(EXT_ENABLE), 16'h0000);
         for (int j = 0; j < 4; j++)
         begin
            a = (j == 0) ? top - 1 : $urandom_range(top - 1);
            op(OPC_WRITE, a, 16'($urandom));
            rd(a, 1);
         end
         op(OPC_WRITE, 0, 16'($urandom));
         rd(top - 1, 2);
         op(OPC_ERASE, a, 16'h0000);
         rd(a, 1);
         op(OPC_EXT, ext_a(EXT_FILL_ALL), 16'($urandom));
         rd($urandom_range(top - 1), 2);
         op(OPC_EXT, ext_a(EXT_CLR_ALL), 16'h0000);
         rd($urandom_range(top - 1), 1);
         op(OPC_EXT, ext_a(EXT_DISABLE), 16'h0000);
      end
      supply_ok <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK(reset_out, 1'b0);
      complete_run();
   end
endmodule : testbench
